// >>> dsi3_disc_pkg.sv
// constants and types shared by the bus slave address discovery block
package dsi3_disc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int SUPPLY_W = 10;
    localparam int AVG_SHIFT = 6;
    localparam logic [SUPPLY_W-1:0] LOW_DROP = 10'h040;
    localparam int CNT_W = 20;
    localparam int FRAME_BITS = 32;
    localparam logic [7:0] CRC_POLY = 8'h2F;
    localparam logic [7:0] CRC_SEED = 8'hFF;
    localparam logic [7:0] CRC_GOOD = 8'h00;
    localparam logic [3:0] GLOBAL_ADDR = 4'h0;
    localparam logic [3:0] FIRST_ADDR = 4'h1;
    localparam logic [3:0] LAST_ADDR = 4'hF;
    localparam logic [3:0] CMD_REG_WRITE = 4'hA;
    localparam logic [7:0] REG_ADDR_IDX = 8'h10;
    localparam logic [7:0] REG_CTRL_IDX = 8'h11;
    localparam int CTRL_BUS_SW_BIT = 0;
    localparam int CTRL_INIT_DONE_BIT = 1;
    localparam logic BUS_SW_RESET = 1'h0;
    localparam logic INIT_DONE_RESET = 1'h0;
    localparam logic DET_RESET = 1'h1;
    localparam logic [1:0] CHIP_NULL = 2'h0;
    localparam logic [1:0] CHIP_TWO = 2'h2;
    // times in their own unit
    localparam int BIT_CELL_NS = 8000;
    localparam int ONE_LOW_MAX_NS = 4000;
    localparam int DISC_LOW_MIN_NS = 16000;
    localparam int IDLE_ABORT_NS = 16000;
    localparam int RSP_DELAY_US = 10;
    localparam int RAMP_US = 40;
    localparam int HOLD_US = 20;
    localparam int START_DISC_US = 2000;
    localparam int DISC_END_US = 6000;
    // the same times as clock cycles
    localparam int BIT_CELL_CYC = (BIT_CELL_NS * CLK_MHZ) / 1000;
    localparam int ONE_LOW_MAX_CYC = (ONE_LOW_MAX_NS * CLK_MHZ) / 1000;
    localparam int DISC_LOW_MIN_CYC = (DISC_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int IDLE_ABORT_CYC = (IDLE_ABORT_NS * CLK_MHZ + 999) / 1000;
    localparam int RSP_DELAY_CYC = RSP_DELAY_US * CLK_MHZ;
    localparam int RAMP_CYC = RAMP_US * CLK_MHZ;
    localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
    localparam int START_DISC_CYC = START_DISC_US * CLK_MHZ;
    localparam int DISC_END_CYC = DISC_END_US * CLK_MHZ;
    typedef enum logic [1:0] {D_WAIT, D_DELAY, D_RAMP, D_HOLD} disc_state_t;
endpackage

// >>> supply_level_tracker.sv
// supply high-level averaging and command comparator
`timescale 1ns/1ns
module supply_level_tracker (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [dsi3_disc_pkg::SUPPLY_W-1:0] i_supply_code,
    output logic o_cmd_detect
);
    localparam int SW = dsi3_disc_pkg::SUPPLY_W;
    localparam int AW = dsi3_disc_pkg::SUPPLY_W + dsi3_disc_pkg::AVG_SHIFT;
    typedef struct packed {
        logic [AW-1:0] acc;
        logic det;
    } trk_t;
    trk_t st_r;
    trk_t st_nxt;
    logic [SW-1:0] avg;
    logic below;

    always_comb begin
        st_nxt = st_r;
        avg = st_r.acc[AW-1:dsi3_disc_pkg::AVG_SHIFT];
        below = ({1'h0, i_supply_code} + {1'h0, dsi3_disc_pkg::LOW_DROP}) < {1'h0, avg};
        if (!below) begin
            // only high samples feed the filter, so commands do not drag the reference down
            st_nxt.acc = st_r.acc - (st_r.acc >> dsi3_disc_pkg::AVG_SHIFT) + AW'(i_supply_code);
        end
        st_nxt.det = !below;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '{acc: '0, det: dsi3_disc_pkg::DET_RESET};
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_cmd_detect = st_r.det;

    avg_frozen_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !o_cmd_detect |-> st_r.acc == $past(st_r.acc))
        else $error("average moved while supply was low");
endmodule // supply_level_tracker

// >>> bus_slave_address_discovery.sv
// bus slave command receiver, address assignment and response current control
`timescale 1ns/1ns

// Functional notes
// - signal class slave, no power class
// - average high level, compare for low
// - comparator low marks command start
// - oscillator counter times received pulses
// - two controls select two current steps
// - sense downstream current during discovery
// - stored nonzero address skips other methods
// - bus switch set by addressed command
// - bus switch off after power-up
// - global write assigns address when unaddressed
// - assigned address used for later exchanges
// - discovery only unaddressed, uninitialised, in window
// - ramp to double current after delay
// - downstream current: stop, count, wait
// - quiet sense: finish ramp, hold level
// - quiet after first hold: take address 1
// - later quiet hold adopts address counter
// - 32-bit frame, address must match
// - bad check value: discard, no response
module bus_slave_address_discovery #(
    parameter int START_DISC_CYC = dsi3_disc_pkg::START_DISC_CYC,
    parameter int DISC_END_CYC = dsi3_disc_pkg::DISC_END_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic [dsi3_disc_pkg::SUPPLY_W-1:0] i_supply_code,
    input wire logic i_sense_high,
    input wire logic [3:0] i_otp_addr,
    input wire logic [1:0] i_tx_chip,
    output logic o_cmd_detect,
    output logic o_cmd_valid,
    output logic [3:0] o_cmd_pa,
    output logic [3:0] o_cmd_code,
    output logic [7:0] o_cmd_ext,
    output logic [7:0] o_cmd_data,
    output logic o_crc_error,
    output logic o_frame_error,
    output logic o_disc_cmd,
    output logic [3:0] o_phys_addr,
    output logic o_init_complete,
    output logic o_bus_switch_on,
    output logic o_disc_ramp,
    output logic o_tx_step1,
    output logic o_tx_step2
);
    localparam int CW = dsi3_disc_pkg::CNT_W;
    localparam logic [CW-1:0] ONE_MAX = CW'(dsi3_disc_pkg::ONE_LOW_MAX_CYC);
    localparam logic [CW-1:0] CELL = CW'(dsi3_disc_pkg::BIT_CELL_CYC);
    localparam logic [CW-1:0] DISC_MIN = CW'(dsi3_disc_pkg::DISC_LOW_MIN_CYC);
    localparam logic [CW-1:0] IDLE_MAX = CW'(dsi3_disc_pkg::IDLE_ABORT_CYC);
    localparam logic [CW-1:0] DELAY_END = CW'(dsi3_disc_pkg::RSP_DELAY_CYC - 1);
    localparam logic [CW-1:0] RAMP_END = CW'(dsi3_disc_pkg::RAMP_CYC - 1);
    localparam logic [CW-1:0] HOLD_END = CW'(dsi3_disc_pkg::HOLD_CYC - 1);
    localparam logic [CW-1:0] WIN_START = CW'(START_DISC_CYC);
    localparam logic [CW-1:0] WIN_END = CW'(DISC_END_CYC);
    localparam logic [5:0] LAST_BIT = 6'(dsi3_disc_pkg::FRAME_BITS - 1);

    typedef struct packed {
        logic loaded;
        logic prev_det;
        logic [CW-1:0] low_cnt;
        logic [CW-1:0] high_cnt;
        logic [5:0] bit_cnt;
        logic [31:0] shift;
        logic [7:0] crc;
        logic cmd_valid;
        logic crc_err;
        logic frame_err;
        logic disc_evt;
        logic [3:0] phys_addr;
        logic init_done;
        logic bus_sw;
        logic [CW-1:0] por_cnt;
        dsi3_disc_pkg::disc_state_t disc;
        logic [CW-1:0] disc_cnt;
        logic [3:0] addr_cnt;
        logic ramp_on;
        logic step1;
        logic step2;
    } st_t;

    localparam st_t RESET_STATE = '{
        crc: dsi3_disc_pkg::CRC_SEED,
        init_done: dsi3_disc_pkg::INIT_DONE_RESET,
        bus_sw: dsi3_disc_pkg::BUS_SW_RESET,
        disc: dsi3_disc_pkg::D_WAIT,
        addr_cnt: dsi3_disc_pkg::FIRST_ADDR,
        prev_det: dsi3_disc_pkg::DET_RESET,
        default: '0
    };

    logic [1:0] rst_sync_r;
    logic rst_n;
    logic cmd_detect;
    st_t st_r;
    st_t st_nxt;
    logic bit_evt;
    logic rx_bit;
    logic disc_now;
    logic abort;
    logic frame_done;
    logic win_open;
    logic eligible;
    logic addr_hit;
    logic [7:0] crc_step;
    logic [31:0] word;

    // reset is released through two flops so every flop behind them leaves reset on the same edge
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_r[1];

    supply_level_tracker u_tracker (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_supply_code(i_supply_code),
        .o_cmd_detect(cmd_detect)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.cmd_valid = 1'h0;
        st_nxt.crc_err = 1'h0;
        st_nxt.frame_err = 1'h0;
        st_nxt.disc_evt = 1'h0;
        st_nxt.prev_det = cmd_detect;
        bit_evt = 1'h0;
        rx_bit = 1'h0;
        disc_now = 1'h0;
        abort = 1'h0;
        frame_done = 1'h0;

        // stored address is taken once, on the first enabled cycle after reset
        if (!st_r.loaded) begin
            st_nxt.loaded = 1'h1;
            st_nxt.phys_addr = i_otp_addr;
        end

        // power-on timer bounds the discovery listening window
        if (st_r.por_cnt < WIN_END) begin
            st_nxt.por_cnt = st_r.por_cnt + CW'(1);
        end
        win_open = (st_r.por_cnt >= WIN_START) && (st_r.por_cnt < WIN_END);
        eligible = st_r.loaded && st_r.phys_addr == dsi3_disc_pkg::GLOBAL_ADDR
            && !st_r.init_done && win_open;

        // pulse timing on the oscillator clock
        if (!cmd_detect) begin
            st_nxt.high_cnt = '0;
            if (st_r.prev_det) begin
                st_nxt.low_cnt = CW'(1);
            end else if (st_r.low_cnt != '1) begin
                st_nxt.low_cnt = st_r.low_cnt + CW'(1);
            end
        end else begin
            if (st_r.high_cnt != '1) begin
                st_nxt.high_cnt = st_r.high_cnt + CW'(1);
            end
            if (!st_r.prev_det) begin
                // end of a low pulse: its length says what it was
                if (st_r.low_cnt < ONE_MAX) begin
                    bit_evt = 1'h1;
                    rx_bit = 1'h1;
                end else if (st_r.low_cnt < CELL) begin
                    bit_evt = 1'h1;
                end else if (st_r.low_cnt >= DISC_MIN) begin
                    disc_now = 1'h1;
                    abort = st_r.bit_cnt != 6'h00;
                end else begin
                    abort = 1'h1;
                    st_nxt.frame_err = 1'h1;
                end
            end else if (st_r.high_cnt == IDLE_MAX && st_r.bit_cnt != 6'h00) begin
                // a microcut or a lost pulse leaves a partial frame; drop it
                abort = 1'h1;
                st_nxt.frame_err = 1'h1;
            end
        end
        st_nxt.disc_evt = disc_now;

        // serial check over message and check field, msb first
        crc_step = {st_r.crc[6:0], rx_bit} ^ (st_r.crc[7] ? dsi3_disc_pkg::CRC_POLY : 8'h00);
        word = {st_r.shift[30:0], rx_bit};
        if (bit_evt) begin
            st_nxt.shift = word;
            st_nxt.crc = crc_step;
            st_nxt.bit_cnt = st_r.bit_cnt + 6'h01;
            if (st_r.bit_cnt == LAST_BIT) begin
                frame_done = 1'h1;
                st_nxt.bit_cnt = 6'h00;
                st_nxt.crc = dsi3_disc_pkg::CRC_SEED;
            end
        end
        if (abort) begin
            st_nxt.bit_cnt = 6'h00;
            st_nxt.crc = dsi3_disc_pkg::CRC_SEED;
        end

        // an unaddressed device answers only the global address
        if (st_r.phys_addr != dsi3_disc_pkg::GLOBAL_ADDR) begin
            addr_hit = word[31:28] == st_r.phys_addr;
        end else begin
            addr_hit = word[31:28] == dsi3_disc_pkg::GLOBAL_ADDR;
        end

        if (frame_done) begin
            if (crc_step != dsi3_disc_pkg::CRC_GOOD) begin
                st_nxt.crc_err = 1'h1;
            end else if (addr_hit) begin
                st_nxt.cmd_valid = 1'h1;
                if (word[27:24] == dsi3_disc_pkg::CMD_REG_WRITE) begin
                    if (word[23:16] == dsi3_disc_pkg::REG_ADDR_IDX
                        && st_r.phys_addr == dsi3_disc_pkg::GLOBAL_ADDR
                        && word[11:8] != dsi3_disc_pkg::GLOBAL_ADDR) begin
                        st_nxt.phys_addr = word[11:8];
                    end else if (word[23:16] == dsi3_disc_pkg::REG_CTRL_IDX
                        && st_r.phys_addr != dsi3_disc_pkg::GLOBAL_ADDR) begin
                        st_nxt.bus_sw = word[8 + dsi3_disc_pkg::CTRL_BUS_SW_BIT];
                        if (word[8 + dsi3_disc_pkg::CTRL_INIT_DONE_BIT]) begin
                            st_nxt.init_done = 1'h1;
                        end
                    end
                end
            end
        end

        // discovery response sequence
        case (st_r.disc)
            dsi3_disc_pkg::D_WAIT: begin
                st_nxt.ramp_on = 1'h0;
                if (disc_now && eligible) begin
                    st_nxt.disc = dsi3_disc_pkg::D_DELAY;
                    st_nxt.disc_cnt = '0;
                end
            end
            dsi3_disc_pkg::D_DELAY: begin
                if (st_r.disc_cnt == DELAY_END) begin
                    st_nxt.disc = dsi3_disc_pkg::D_RAMP;
                    st_nxt.disc_cnt = '0;
                    st_nxt.ramp_on = 1'h1;
                end else begin
                    st_nxt.disc_cnt = st_r.disc_cnt + CW'(1);
                end
            end
            dsi3_disc_pkg::D_RAMP,
            dsi3_disc_pkg::D_HOLD: begin
                if (i_sense_high) begin
                    // a slave further down draws current, so this is not the last one
                    st_nxt.ramp_on = 1'h0;
                    st_nxt.disc = dsi3_disc_pkg::D_WAIT;
                    if (st_r.addr_cnt != dsi3_disc_pkg::LAST_ADDR) begin
                        st_nxt.addr_cnt = st_r.addr_cnt + 4'h1;
                    end
                end else if (st_r.disc == dsi3_disc_pkg::D_RAMP && st_r.disc_cnt == RAMP_END) begin
                    st_nxt.disc = dsi3_disc_pkg::D_HOLD;
                    st_nxt.disc_cnt = '0;
                end else if (st_r.disc == dsi3_disc_pkg::D_HOLD && st_r.disc_cnt == HOLD_END) begin
                    st_nxt.phys_addr = st_r.addr_cnt;
                    st_nxt.ramp_on = 1'h0;
                    st_nxt.disc = dsi3_disc_pkg::D_WAIT;
                end else begin
                    st_nxt.disc_cnt = st_r.disc_cnt + CW'(1);
                end
            end
            default: begin
                st_nxt.disc = dsi3_disc_pkg::D_WAIT;
                st_nxt.ramp_on = 1'h0;
            end
        endcase

        // only current modulation is driven; discovery ramp takes the driver over
        st_nxt.step1 = !st_nxt.ramp_on && i_tx_chip != dsi3_disc_pkg::CHIP_NULL;
        st_nxt.step2 = !st_nxt.ramp_on && i_tx_chip == dsi3_disc_pkg::CHIP_TWO;
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= RESET_STATE;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_cmd_detect = cmd_detect;
    assign o_cmd_valid = st_r.cmd_valid;
    assign o_cmd_pa = st_r.shift[31:28];
    assign o_cmd_code = st_r.shift[27:24];
    assign o_cmd_ext = st_r.shift[23:16];
    assign o_cmd_data = st_r.shift[15:8];
    assign o_crc_error = st_r.crc_err;
    assign o_frame_error = st_r.frame_err;
    assign o_disc_cmd = st_r.disc_evt;
    assign o_phys_addr = st_r.phys_addr;
    assign o_init_complete = st_r.init_done;
    assign o_bus_switch_on = st_r.bus_sw;
    assign o_disc_ramp = st_r.ramp_on;
    assign o_tx_step1 = st_r.step1;
    assign o_tx_step2 = st_r.step2;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence ramp_leave_s;
        (st_r.disc == dsi3_disc_pkg::D_RAMP || st_r.disc == dsi3_disc_pkg::D_HOLD) && i_sense_high && i_ce;
    endsequence
    sequence hold_done_s;
        st_r.disc == dsi3_disc_pkg::D_HOLD && st_r.disc_cnt == HOLD_END && !i_sense_high && i_ce;
    endsequence

    bus_sw_cmd_a: assert property ($rose(st_r.bus_sw) |-> st_r.cmd_valid)
        else $error("bus switch turned on without a command");
    crc_discard_a: assert property (st_r.crc_err |-> !st_r.cmd_valid)
        else $error("command accepted with a bad check value");
    addr_match_a: assert property (st_r.cmd_valid && $past(st_r.phys_addr) != 4'h0
        |-> st_r.shift[31:28] == $past(st_r.phys_addr))
        else $error("command accepted for another address");
    disc_quiet_a: assert property ($rose(st_r.disc == dsi3_disc_pkg::D_DELAY)
        |-> $past(st_r.phys_addr) == 4'h0 && !$past(st_r.init_done))
        else $error("addressed device entered discovery");
    delay_len_a: assert property ($rose(st_r.disc == dsi3_disc_pkg::D_RAMP)
        |-> $past(st_r.disc_cnt) == DELAY_END && st_r.ramp_on)
        else $error("ramp started after the wrong delay");
    sense_stop_a: assert property (ramp_leave_s |=> !st_r.ramp_on ##0
        st_r.disc == dsi3_disc_pkg::D_WAIT)
        else $error("ramp kept on with downstream current");
    ramp_len_a: assert property ($rose(st_r.disc == dsi3_disc_pkg::D_HOLD)
        |-> $past(st_r.disc_cnt) == RAMP_END)
        else $error("hold reached after the wrong ramp time");
    adopt_addr_a: assert property (hold_done_s |=> st_r.phys_addr == $past(st_r.addr_cnt)
        && !st_r.ramp_on)
        else $error("address counter not adopted after hold");
    start_low_a: assert property (st_r.prev_det && !cmd_detect && i_ce |=> st_r.low_cnt == 20'h00001)
        else $error("low pulse timing did not start at one");
    step_off_a: assert property (st_r.ramp_on |-> !st_r.step1 && !st_r.step2)
        else $error("modulation steps on during discovery ramp");
endmodule // bus_slave_address_discovery

// >>> dsi3_master_model.sv
// bus master and downstream slave model for the discovery block
`timescale 1ns/1ns
module dsi3_master_model (
    input wire logic i_core_clk,
    output logic [dsi3_disc_pkg::SUPPLY_W-1:0] o_supply_code,
    output logic o_sense_high
);
    // unaddressed slaves behind the device on its downstream supply
    int downstream = 0;

    initial begin
        o_supply_code = 10'h300;
        o_sense_high = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    // bus low for n cycles, then high for gap cycles
    task automatic pulse(input int n, input int gap);
        o_supply_code = 10'h100;
        wait_cyc(n);
        o_supply_code = 10'h300;
        wait_cyc(gap);
    endtask

    task automatic send_frame(input logic [31:0] f);
        for (int i = 31; i >= 0; i--) begin
            pulse(f[i] ? 10 : 405, 5);
        end
        wait_cyc(20);
    endtask

    // a downstream slave ramps too and shows up mid-ramp on the sense path
    task automatic discovery();
        pulse(1700, 1100);
        if (downstream > 0) begin
            o_sense_high = 1'b1;
            wait_cyc(1000);
            o_sense_high = 1'b0;
            downstream--;
        end else begin
            wait_cyc(1000);
        end
        wait_cyc(4950);
    endtask
endmodule // dsi3_master_model

// >>> tb.sv
// self-checking bench for the bus slave address discovery block
`timescale 1ns/1ns
module tb;
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [3:0] otp_addr = 4'h0;
    logic [1:0] tx_chip = 2'h0;
    wire logic [dsi3_disc_pkg::SUPPLY_W-1:0] supply_code;
    wire logic sense_high;
    logic cmd_valid, crc_error, disc_cmd, init_complete, bus_switch_on, disc_ramp, tx_step1, tx_step2;
    logic cmd_detect, frame_error;
    logic [3:0] cmd_pa, cmd_code, phys_addr;
    logic [7:0] cmd_ext, cmd_data;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    int disc_at = 0;
    int lag = 0;
    int ramp_cnt = 0;
    int low_cyc = 0;
    int ferr_cnt = 0;
    logic [25:0] seen_f;
    logic [31:0] lfsr = 32'h92A3;
    logic [25:0] expect_q[$];

    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end

    // short window bounds keep the run brief
    bus_slave_address_discovery #(.START_DISC_CYC(50), .DISC_END_CYC(40000)) dut_u (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_supply_code(supply_code),
        .i_sense_high(sense_high), .i_otp_addr(otp_addr), .i_tx_chip(tx_chip), .o_cmd_detect(cmd_detect),
        .o_cmd_valid(cmd_valid), .o_cmd_pa(cmd_pa), .o_cmd_code(cmd_code), .o_cmd_ext(cmd_ext),
        .o_cmd_data(cmd_data), .o_crc_error(crc_error), .o_frame_error(frame_error), .o_disc_cmd(disc_cmd),
        .o_phys_addr(phys_addr), .o_init_complete(init_complete), .o_bus_switch_on(bus_switch_on),
        .o_disc_ramp(disc_ramp), .o_tx_step1(tx_step1), .o_tx_step2(tx_step2));

    dsi3_master_model master_u (.i_core_clk(i_core_clk), .o_supply_code(supply_code), .o_sense_high(sense_high));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        check("queue left", expect_q.size(), 0);
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // check byte: seed FF, message then eight zeros shifted in msb first
    function automatic logic [7:0] crc_of(input logic [23:0] d);
        logic [7:0] c;
        logic [31:0] m;
        c = 8'hFF;
        m = {d, 8'h00};
        for (int i = 31; i >= 0; i--) c = {c[6:0], m[i]} ^ (c[7] ? 8'h2F : 8'h00);
        return c;
    endfunction

    // ramp timing monitor, sampled one edge late for both events alike
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (disc_cmd === 1'b1) disc_at <= cyc;
        if (disc_ramp === 1'b1) ramp_cnt <= ramp_cnt + 1;
        if (disc_ramp === 1'b1 && ramp_cnt == 0) lag <= cyc - disc_at;
        if (cmd_detect === 1'b0) low_cyc <= low_cyc + 1;
        if (frame_error === 1'b1) ferr_cnt <= ferr_cnt + 1;
    end

    // frame results are matched against the oldest note
    always @(posedge i_core_clk) begin
        if (cmd_valid === 1'b1 || crc_error === 1'b1) begin
            seen_f = {cmd_valid, crc_error, crc_error ? 24'h0 : {cmd_pa, cmd_code, cmd_ext, cmd_data}};
            if (expect_q.size() == 0) check("unexpected frame", 0, 1);
            else check("frame", seen_f, expect_q.pop_front());
        end
    end

    task automatic frame(input logic [23:0] d, input logic bad, input logic hit);
        logic [7:0] c;
        c = crc_of(d) ^ {7'h0, bad};
        if (hit) expect_q.push_back(bad ? {2'b01, 24'h0} : {2'b10, d});
        master_u.send_frame({d, c});
    endtask

    task automatic do_reset(input logic [3:0] otp);
        @(posedge i_core_clk);
        #1;
        i_arst_n = 1'b0;
        otp_addr = otp;
        master_u.downstream = 0;
        repeat (8) @(posedge i_core_clk);
        #1;
        i_arst_n = 1'b1;
        // let the high-level average settle before any traffic
        master_u.wait_cyc(300);
        check("switch", bus_switch_on, 0);
        check("init", init_complete, 0);
        check("addr", phys_addr, otp);
    endtask

    task automatic disc(input int exp_len, input logic [3:0] exp_addr);
        ramp_cnt = 0;
        master_u.discovery();
        check("ramp", ramp_cnt inside {[exp_len-5:exp_len+5]}, 1);
        if (exp_len > 0) check("lag", lag inside {[999:1001]}, 1);
        check("addr", phys_addr, exp_addr);
    endtask

    task automatic tx_test();
        for (int i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            tx_chip = (i < 4) ? i[1:0] : lfsr[1:0];
            master_u.wait_cyc(1);
            check("step1", tx_step1, tx_chip != 2'h0);
            check("step2", tx_step2, tx_chip == 2'h2);
        end
        $display("test transmit done");
    endtask

    initial begin
        do_reset(4'h0);
        tx_test();
        disc(6000, 4'h1);
        disc(0, 4'h1);
        frame({4'h1, 4'hA, 8'h11, 8'h01}, 1'b0, 1'b1);
        check("switch", bus_switch_on, 1);
        frame({4'h2, 4'hA, 8'h11, 8'h03}, 1'b0, 1'b0);
        frame({4'h1, 4'hA, 8'h11, 8'h03}, 1'b1, 1'b1);
        check("init", init_complete, 0);
        $display("test first discovery done");
        do_reset(4'h0);
        master_u.downstream = 1;
        disc(100, 4'h0);
        disc(6000, 4'h2);
        $display("test chained discovery done");
        do_reset(4'h0);
        // a low pulse between bit and discovery length is refused as a frame error
        low_cyc = 0;
        ferr_cnt = 0;
        master_u.pulse(1000, 10);
        check("low time", low_cyc, 1000);
        check("frame error", ferr_cnt, 1);
        frame({4'h0, 4'hA, 8'h10, 8'h05}, 1'b0, 1'b1);
        check("addr", phys_addr, 4'h5);
        frame({4'h5, 4'hA, 8'h11, 8'h02}, 1'b0, 1'b1);
        check("init", init_complete, 1);
        $display("test global write done");
        do_reset(4'h3);
        disc(0, 4'h3);
        $display("test stored address done");
        wrap_up();
    end

    // tests need about 91000 cycles, a little more for zero-heavy check bytes
    initial begin
        #1000000;
        check("watchdog", 1, 0);
        wrap_up();
    end
endmodule // tb
